// >>> gbbp_consts.svh
/*
  register offsets, field positions, response codes and timing figures
  for the byte bus port; assumes inclusion by its bare name.
*/
`ifndef GBBP_CONSTS_SVH
`define GBBP_CONSTS_SVH
`define GBBP_CLK_MHZ        40
`define GBBP_STROBE_MIN_NS  50
`define GBBP_MRST_MIN_NS    2000
`define GBBP_OFF_DIR        8'h00
`define GBBP_OFF_OUT        8'h04
`define GBBP_OFF_IN         8'h08
`define GBBP_OFF_BUSDIR     8'h0C
`define GBBP_OFF_BUSOUT     8'h10
`define GBBP_OFF_BUSLATCH   8'h14
`define GBBP_OFF_STATUS     8'h18
`define GBBP_OFF_CTRL       8'h1C
`define GBBP_CTRL_STROBE_EN 0
`define GBBP_ST_RD_DONE     0
`define GBBP_ST_WR_DONE     1
`define GBBP_ST_FRAME       2
`define GBBP_ST_BATLOW      3
`define GBBP_ST_MRST        4
`define GBBP_RESP_OKAY      2'b00
`define GBBP_RESP_SLVERR    2'b10
`endif

// >>> gbbp_pkg.sv
/*
  types for the byte bus port.
  assumes gbbp_consts.svh is on the include path.
*/
`default_nettype none
package gbbp_pkg;
  typedef enum logic [1:0] {gbbp_idle, gbbp_low, gbbp_done} gbbp_strobe_type;
endpackage : gbbp_pkg
`default_nettype wire

// >>> gbbp_strobe.sv
/*
  low-pulse qualifier: reports a qualified low pulse on a synchronised
  strobe once it returns high. assumes input already synchronised.
*/
`default_nettype none
`include "gbbp_consts.svh"
module gbbp_strobe #(
  parameter int MIN_CYCLES = 2
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic strobe_n,
  output logic      pulse
);
  import gbbp_pkg::*;
  gbbp_strobe_type state;
  gbbp_strobe_type next_state;
  logic [7:0]      count;
  logic [7:0]      next_count;
  logic            next_pulse;

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_pulse = 1'b0;
    case (state)
      gbbp_idle:
      begin
        next_count = 8'h00;
        if (!strobe_n)
          next_state = gbbp_low;
      end
      gbbp_low:
      begin
        if (strobe_n)
        begin
          next_state = gbbp_idle;
          next_pulse = (count >= 8'(MIN_CYCLES - 1));
        end
        else if (count != 8'hFF)
          next_count = count + 8'h01;
      end
      default:
        next_state = gbbp_idle;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= gbbp_idle;
      count <= 8'h00;
      pulse <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      pulse <= next_pulse;
    end
  end
endmodule : gbbp_strobe
`default_nettype wire

// >>> gbbp_port.sv
/*
  gpio block: five single pins, an eight-line byte bus with read and
  write strobes, behind an axi4-lite slave.
  assumes pins are resolved outside from out/oe (oe low = driving).
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
// Functional notes
// [R1] thirteen lines: five single plus eight bus
// [R2] all lines inputs after reset
// [R3] each single pin has own direction
// [R4] bus lines handled only as one byte
// [R5] strobe low pulse at least 50 ns
// [R6] read strobe latches bus byte in
// [R7] write strobe drives and holds byte
// [R8] power pin high enables card and display
// [R9] power pin as input lets outside drive
// [R10] frame mark read as input pin
// [R11] battery low read as input pin
// [R12] master reset low over 2 us resets
// [R13] bus undriven during read
`default_nettype none
`include "gbbp_consts.svh"
module gbbp_port #(
  parameter int MRST_CYCLES = (`GBBP_MRST_MIN_NS * `GBBP_CLK_MHZ + 999) / 1000
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [4:0]  single_pins_in,
  output logic [4:0]       single_pins_out,
  output logic [4:0]       single_pins_oe_n,
  input  wire logic [7:0]  parallel_byte_lines_in,
  output logic [7:0]       parallel_byte_lines_out,
  output logic [7:0]       parallel_byte_lines_oe_n,
  input  wire logic        master_reset_n_in,
  output logic             module_reset_n
);
  import gbbp_pkg::*;
  // pin index: 0 frame_mark_pin, 1 battery_low_pin,
  // 2 peripheral_power_enable_pin, 3 general_pin_4, 4 general_pin_5
  localparam int STROBE_CYCLES =
    (`GBBP_STROBE_MIN_NS * `GBBP_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0]  pin_meta;
  logic [4:0]  pin_sync;
  logic [7:0]  bus_meta;
  logic [7:0]  bus_sync;
  logic        mrst_meta;
  logic        mrst_sync;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta  <= 5'h1F;
      pin_sync  <= 5'h1F;
      bus_meta  <= 8'h00;
      bus_sync  <= 8'h00;
      mrst_meta <= 1'b1;
      mrst_sync <= 1'b1;
    end
    else
    begin
      pin_meta  <= single_pins_in;
      pin_sync  <= pin_meta;
      bus_meta  <= parallel_byte_lines_in;
      bus_sync  <= bus_meta;
      mrst_meta <= master_reset_n_in;
      mrst_sync <= mrst_meta;
    end
  end

  // ----------------------------------------------------------------
  // strobe qualifiers
  // ----------------------------------------------------------------
  logic rd_pulse;
  logic wr_pulse;

  gbbp_strobe #(.MIN_CYCLES(STROBE_CYCLES)) u_rd (
    .clock    (clock),
    .nrst     (nrst),
    .strobe_n (pin_sync[3]),
    .pulse    (rd_pulse)
  ); // [R5]

  gbbp_strobe #(.MIN_CYCLES(STROBE_CYCLES)) u_wr (
    .clock    (clock),
    .nrst     (nrst),
    .strobe_n (pin_sync[4]),
    .pulse    (wr_pulse)
  ); // [R5]

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [4:0]  dir;
  logic [4:0]  next_dir;
  logic [4:0]  out_val;
  logic [4:0]  next_out_val;
  logic        bus_dir;
  logic        next_bus_dir;
  logic [7:0]  bus_out;
  logic [7:0]  next_bus_out;
  logic [7:0]  bus_latch;
  logic [7:0]  next_bus_latch;
  logic [7:0]  bus_hold;
  logic [7:0]  next_bus_hold;
  logic        bus_drive;
  logic        next_bus_drive;
  logic        strobe_en;
  logic        next_strobe_en;
  logic [4:0]  status;
  logic [4:0]  next_status;
  logic [15:0] mrst_count;
  logic [15:0] next_mrst_count;
  logic        mrst_hit;
  logic        next_mrst_hit;
  logic        rd_low;
  logic        next_rd_low;
  logic        rd_release;

  // axi state
  logic        aw_held;
  logic        next_aw_held;
  logic        w_held;
  logic        next_w_held;
  logic [7:0]  aw_addr;
  logic [7:0]  next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= `GBBP_OFF_CTRL) && (a[1:0] == 2'b00);
  endfunction : addr_ok

  logic        do_write;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;

  always_comb
  begin
    next_aw_held   = aw_held;
    next_w_held    = w_held;
    next_aw_addr   = aw_addr;
    next_w_data    = w_data;
    next_w_strb    = w_strb;
    next_bvalid    = s_axi_bvalid;
    next_bresp     = s_axi_bresp;
    next_rvalid    = s_axi_rvalid;
    next_rdata     = s_axi_rdata;
    next_rresp     = s_axi_rresp;
    next_dir       = dir;
    next_out_val   = out_val;
    next_bus_dir   = bus_dir;
    next_bus_out   = bus_out;
    next_bus_latch = bus_latch;
    next_bus_hold  = bus_hold;
    next_bus_drive = bus_drive;
    next_strobe_en = strobe_en;
    next_status    = status;
    next_mrst_hit  = 1'b0;
    next_rd_low    = !pin_sync[3];
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = next_aw_held && next_w_held && !s_axi_bvalid;
    wa = next_aw_addr;
    wd = next_w_data;
    ws = next_w_strb;
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = addr_ok(wa) ? `GBBP_RESP_OKAY : `GBBP_RESP_SLVERR;
      if (ws[0])
      begin
        case (wa)
          `GBBP_OFF_DIR:    next_dir = wd[4:0];       // [R3]
          `GBBP_OFF_OUT:    next_out_val = wd[4:0];   // [R8]
          `GBBP_OFF_BUSDIR: next_bus_dir = wd[0];
          `GBBP_OFF_BUSOUT: next_bus_out = wd[7:0];   // [R4]
          `GBBP_OFF_STATUS: next_status = status & ~wd[4:0];
          `GBBP_OFF_CTRL:   next_strobe_en = wd[`GBBP_CTRL_STROBE_EN];
          default:          ;
        endcase
      end
    end
    // strobes act only while enabled and the strobe pins are inputs
    if (strobe_en && !dir[3] && rd_pulse)
    begin
      next_bus_latch = bus_sync;                      // [R6]
      next_bus_drive = 1'b0;                          // [R13]
      next_status[`GBBP_ST_RD_DONE] = 1'b1;           // set wins over clear
    end
    if (strobe_en && !dir[4] && wr_pulse)
    begin
      next_bus_hold  = bus_out;                       // [R7]
      next_bus_drive = 1'b1;                          // [R7]
      next_status[`GBBP_ST_WR_DONE] = 1'b1;
    end
    // frame mark and battery low as sticky events when inputs
    if (!dir[0] && !pin_sync[0])
      next_status[`GBBP_ST_FRAME] = 1'b1;             // [R10]
    if (!dir[1] && !pin_sync[1])
      next_status[`GBBP_ST_BATLOW] = 1'b1;            // [R11]
    next_mrst_count = mrst_sync ? 16'h0000 : mrst_count;
    if (!mrst_sync && mrst_count != 16'(MRST_CYCLES))
      next_mrst_count = mrst_count + 16'h0001;
    if (!mrst_sync && mrst_count == 16'(MRST_CYCLES - 1))
      next_mrst_hit = 1'b1;                           // [R12]
    if (mrst_hit)
    begin
      next_dir       = 5'h00;                         // [R2]
      next_out_val   = 5'h00;
      next_bus_dir   = 1'b0;
      next_bus_drive = 1'b0;
      next_strobe_en = 1'b0;
      next_status    = 5'h00;
      next_status[`GBBP_ST_MRST] = 1'b1;
    end
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = addr_ok(s_axi_araddr[7:0]) ? `GBBP_RESP_OKAY : `GBBP_RESP_SLVERR;
      case (s_axi_araddr[7:0])
        `GBBP_OFF_DIR:      next_rdata = {27'h0, dir};
        `GBBP_OFF_OUT:      next_rdata = {27'h0, out_val};
        `GBBP_OFF_IN:       next_rdata = {27'h0, pin_sync};
        `GBBP_OFF_BUSDIR:   next_rdata = {31'h0, bus_dir};
        `GBBP_OFF_BUSOUT:   next_rdata = {24'h0, bus_out};
        `GBBP_OFF_BUSLATCH: next_rdata = {24'h0, strobe_en ? bus_latch : bus_sync};
        `GBBP_OFF_STATUS:   next_rdata = {27'h0, status};
        `GBBP_OFF_CTRL:     next_rdata = {31'h0, strobe_en};
        default:            next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // pin drive: oe_n low means driving
  logic [4:0] next_pins_oe_n;
  logic [7:0] next_bus_oe_n;
  logic [7:0] next_bus_val;
  always_comb
  begin
    // held off one cycle past the strobe so the latch sees the far byte
    rd_release     = strobe_en && !dir[3] && (!pin_sync[3] || rd_low);
    next_pins_oe_n = ~next_dir;                       // [R9]
    if (next_strobe_en)
    begin
      next_bus_oe_n = (next_bus_drive && !rd_release) ? 8'h00 : 8'hFF; // [R13]
      next_bus_val  = next_bus_hold;
    end
    else
    begin
      next_bus_oe_n = next_bus_dir ? 8'h00 : 8'hFF;   // [R4]
      next_bus_val  = next_bus_out;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dir                      <= 5'h00;              // [R2]
      out_val                  <= 5'h00;
      bus_dir                  <= 1'b0;
      bus_out                  <= 8'h00;
      bus_latch                <= 8'h00;
      bus_hold                 <= 8'h00;
      bus_drive                <= 1'b0;
      strobe_en                <= 1'b0;
      status                   <= 5'h00;
      mrst_count               <= 16'h0000;
      mrst_hit                 <= 1'b0;
      rd_low                   <= 1'b0;
      aw_held                  <= 1'b0;
      w_held                   <= 1'b0;
      aw_addr                  <= 8'h00;
      w_data                   <= 32'h0000_0000;
      w_strb                   <= 4'h0;
      s_axi_bvalid             <= 1'b0;
      s_axi_bresp              <= 2'b00;
      s_axi_rvalid             <= 1'b0;
      s_axi_rdata              <= 32'h0000_0000;
      s_axi_rresp              <= 2'b00;
      s_axi_awready            <= 1'b0;
      s_axi_wready             <= 1'b0;
      s_axi_arready            <= 1'b0;
      single_pins_out          <= 5'h00;
      single_pins_oe_n         <= 5'h1F;              // [R1]
      parallel_byte_lines_out  <= 8'h00;
      parallel_byte_lines_oe_n <= 8'hFF;
      module_reset_n           <= 1'b1;
    end
    else
    begin
      dir                      <= next_dir;
      out_val                  <= next_out_val;
      bus_dir                  <= next_bus_dir;
      bus_out                  <= next_bus_out;
      bus_latch                <= next_bus_latch;
      bus_hold                 <= next_bus_hold;
      bus_drive                <= next_bus_drive;
      strobe_en                <= next_strobe_en;
      status                   <= next_status;
      mrst_count               <= next_mrst_count;
      mrst_hit                 <= next_mrst_hit;
      rd_low                   <= next_rd_low;
      aw_held                  <= next_aw_held;
      w_held                   <= next_w_held;
      aw_addr                  <= next_aw_addr;
      w_data                   <= next_w_data;
      w_strb                   <= next_w_strb;
      s_axi_bvalid             <= next_bvalid;
      s_axi_bresp              <= next_bresp;
      s_axi_rvalid             <= next_rvalid;
      s_axi_rdata              <= next_rdata;
      s_axi_rresp              <= next_rresp;
      // one beat per channel; ready drops while a word is held
      s_axi_awready            <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready             <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready            <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      single_pins_out          <= next_out_val;
      single_pins_oe_n         <= next_pins_oe_n;
      parallel_byte_lines_out  <= next_bus_val;
      parallel_byte_lines_oe_n <= next_bus_oe_n;
      module_reset_n           <= !next_mrst_hit;     // [R12]
    end
  end
endmodule : gbbp_port
`default_nettype wire

// >>> gbbp_port_assertions.sv
/*
  checker for gbbp_port: bus answer timing, pin directions, master reset.
  assumes it is bound to gbbp_port and sees only that module's ports.
*/
`default_nettype none
module gbbp_port_assertions #(
  parameter int MRST_CYCLES = 80
) (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [4:0] single_pins_oe_n,
  input wire logic [7:0] parallel_byte_lines_oe_n,
  input wire logic       master_reset_n_in,
  input wire logic       module_reset_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_inputs: assert property ($rose(nrst) |->
    &single_pins_oe_n && &parallel_byte_lines_oe_n) else $error("pins not inputs");
  a_byte_whole: assert property (parallel_byte_lines_oe_n inside {8'h00, 8'hff})
    else $error("bus lines split");
  a_write_answer: assert property (s_wtake |=> s_axi_bvalid) else $error("no write answer");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_read_answer: assert property (s_rtake |=> s_axi_rvalid) else $error("no read answer");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
  a_mrst_pulse: assert property (!module_reset_n |=> module_reset_n)
    else $error("reset pulse too long");
  // pin is synchronised first, so it was low some cycles before the pulse
  a_mrst_cause: assert property ($fell(module_reset_n) |-> !$past(master_reset_n_in, 3))
    else $error("reset without low pin");
endmodule : gbbp_port_assertions
`default_nettype wire

// >>> gbbp_ext.sv
/*
  circuitry on the expansion header: resolves each pin from the block's
  drive and an outside driver. assumes oe_n low means the block drives.
*/
`default_nettype none
module gbbp_ext (
  input  wire logic [4:0] single_pins_out,
  input  wire logic [4:0] single_pins_oe_n,
  input  wire logic [4:0] ext_s_val,
  input  wire logic [4:0] ext_s_en,
  input  wire logic [7:0] parallel_byte_lines_out,
  input  wire logic [7:0] parallel_byte_lines_oe_n,
  input  wire logic [7:0] ext_b_val,
  input  wire logic       ext_b_en,
  input  wire logic       ext_mrst_low,
  input  wire logic       clock,
  output logic [4:0]      single_pins_in,
  output logic [7:0]      parallel_byte_lines_in,
  output logic            master_reset_n_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] drift = 8'h5a;
  // released lines float: a changing pattern, never the last value
  always @(posedge clock) drift <= drift + 8'h3b;
  assign single_pins_in = (~single_pins_oe_n & single_pins_out)
                        | (single_pins_oe_n & ext_s_en & ext_s_val)
                        | (single_pins_oe_n & ~ext_s_en & drift[4:0]);
  assign parallel_byte_lines_in = (~parallel_byte_lines_oe_n & parallel_byte_lines_out)
                                | (parallel_byte_lines_oe_n & (ext_b_en ? ext_b_val : drift));
  // open-collector pull-down against the on-board pull-up
  assign master_reset_n_in = !ext_mrst_low;
endmodule : gbbp_ext
`default_nettype wire

// >>> gbbp_port_tb_top.sv
/*
  testbench for gbbp_port: axi4-lite master, pin model, model in integers.
  assumes gbbp_ext and gbbp_port_assertions are compiled before it.
*/
`default_nettype none
`include "gbbp_consts.svh"
module gbbp_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0, nrst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        master_reset_n_in, module_reset_n, ext_b_en = 1'b0, ext_mrst_low = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, got;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0]  single_pins_in, single_pins_out, single_pins_oe_n;
  logic [4:0]  ext_s_val = 5'h1b, ext_s_en = 5'h1f;
  logic [7:0]  parallel_byte_lines_in, parallel_byte_lines_out, parallel_byte_lines_oe_n;
  logic [7:0]  ext_b_val = 8'h00;
  int          bad_count = 0, n_compared = 0, m_dir, m_out, exp_q[$];
  always #12.5 clock = ~clock;
  gbbp_port #(.MRST_CYCLES(4)) gbbp_port_i (.*);
  gbbp_ext gbbp_ext_i (.*);
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr  <= {24'h0, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr  <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    got = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic strobe(input int pin, input int len);
    @(posedge clock);
    ext_s_val[pin] <= 1'b0;
    repeat (len) @(posedge clock);
    ext_s_val[pin] <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : strobe
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (4000) @(posedge clock);
    bad_count++;
    close_out();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(82337));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    cmp({19'h0, single_pins_oe_n, parallel_byte_lines_oe_n}, 32'h1fff);
    for (int i = 0; i < 9; i++)
    begin
      if (i == 5) continue;
      rd(8'(i * 4));
      cmp(got, (i == 2) ? 32'h1b : 32'h0);
      cmp({30'h0, rsp}, (i == 8) ? `GBBP_RESP_SLVERR : `GBBP_RESP_OKAY);
    end
    wr(8'h20, 32'h0);
    cmp({30'h0, rsp}, `GBBP_RESP_SLVERR);
    repeat (4)
    begin
      m_dir = $urandom & 32'h1f;
      m_out = $urandom & 32'h1f;
      wr(`GBBP_OFF_OUT, m_out);
      wr(`GBBP_OFF_DIR, m_dir);
      repeat (4) @(posedge clock);
      cmp(single_pins_oe_n, ~m_dir & 32'h1f);
      cmp(single_pins_out & m_dir, m_out & m_dir);
      rd(`GBBP_OFF_IN);
      cmp(got, (m_out & m_dir) | (32'h1b & ~m_dir));
    end
    wr(`GBBP_OFF_DIR, 32'h0);
    ext_s_val <= 5'h18;
    repeat (4) @(posedge clock);
    rd(`GBBP_OFF_STATUS);
    cmp(got, 32'hc);
    ext_s_val <= 5'h1b;
    // let the synced pins go high first, else the set beats the clear
    repeat (4) @(posedge clock);
    wr(`GBBP_OFF_STATUS, 32'hc);
    wr(`GBBP_OFF_CTRL, 32'h1);
    cmp({30'h0, rsp}, `GBBP_RESP_OKAY);
    exp_q.push_back($urandom & 32'hff);
    ext_b_val <= 8'(exp_q[0]);
    ext_b_en  <= 1'b1;
    strobe(3, 3);
    cmp(parallel_byte_lines_oe_n, 32'hff);
    rd(`GBBP_OFF_BUSLATCH);
    cmp(got, exp_q.pop_front());
    rd(`GBBP_OFF_STATUS);
    cmp(got, 32'h1);
    ext_b_en <= 1'b0;
    m_out = $urandom & 32'hff;
    wr(`GBBP_OFF_BUSOUT, m_out);
    strobe(4, 2);
    wr(`GBBP_OFF_BUSOUT, ~m_out & 32'hff);
    cmp({parallel_byte_lines_oe_n, parallel_byte_lines_out}, m_out);
    strobe(3, 1);
    cmp(parallel_byte_lines_oe_n, 32'h0);
    exp_q.push_back($urandom & 32'hff);
    ext_b_val <= 8'(exp_q[0]);
    ext_b_en  <= 1'b1;
    strobe(3, 2);
    cmp(parallel_byte_lines_oe_n, 32'hff);
    rd(`GBBP_OFF_BUSLATCH);
    cmp(got, exp_q.pop_front());
    wr(`GBBP_OFF_DIR, 32'h4);
    ext_mrst_low <= 1'b1;
    repeat (8) @(posedge clock);
    ext_mrst_low <= 1'b0;
    repeat (8) @(posedge clock);
    cmp(single_pins_oe_n, 32'h1f);
    rd(`GBBP_OFF_STATUS);
    cmp(got, 32'h10);
    close_out();
  end
endmodule : gbbp_port_tb_top
bind gbbp_port gbbp_port_assertions #(.MRST_CYCLES(MRST_CYCLES)) gbbp_port_assertions_i (.*);
`default_nettype wire
